// ---- design/bus_watchdog.sv ----
// Control bus watchdog: bus-free detection and nine-pulse bus clear
`timescale 1ns/100ps
module bus_watchdog #(
  parameter int unsigned LONG_CYCLES  = serctl_pkg::WDOG_LONG_CYCLES,
  parameter int unsigned SHORT_CYCLES = serctl_pkg::WDOG_SHORT_CYCLES,
  parameter int unsigned HALF_CYCLES  = serctl_pkg::CLEAR_HALF_CYCLES,
  parameter int          CNT_W        = 24
) (
  input  wire logic i_clock,
  input  wire logic i_rst_n,
  input  wire logic i_disable,
  input  wire logic i_speedup,
  input  wire logic i_scl_in,
  input  wire logic i_sda_in,
  output logic      o_scl_out,
  output logic      o_scl_oe_n,
  output logic      o_bus_free,
  output logic      o_bus_clearing
);
  import serctl_pkg::*;

  typedef enum logic [3:0] {
    WATCH  = 4'b0001,
    FREE   = 4'b0010,
    CLR_LO = 4'b0100,
    CLR_HI = 4'b1000
  } wd_state_e;

  wd_state_e        state_r;
  logic [CNT_W-1:0] idle_cnt_r;
  logic [CNT_W-1:0] limit;
  logic [7:0]       half_cnt_r;
  logic [3:0]       pulse_cnt_r;
  logic             scl_prev_r;
  logic             sda_prev_r;
  logic             activity;
  logic             expired;
  logic             half_tick;

  assign limit     = i_speedup ? CNT_W'(SHORT_CYCLES - 1) : CNT_W'(LONG_CYCLES - 1);
  assign activity  = (i_scl_in != scl_prev_r) || (i_sda_in != sda_prev_r);
  assign expired   = !activity && idle_cnt_r >= limit;
  assign half_tick = half_cnt_r == 8'(HALF_CYCLES - 1);

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      scl_prev_r <= 1'b1;
      sda_prev_r <= 1'b1;
    end else begin
      scl_prev_r <= i_scl_in;
      sda_prev_r <= i_sda_in;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n || i_disable || state_r != WATCH || activity) begin
      idle_cnt_r <= '0;
    end else if (!expired) begin
      idle_cnt_r <= idle_cnt_r + 1'b1;
    end
  end

  // Clear-pulse rate divider
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || !(state_r == CLR_LO || state_r == CLR_HI) || half_tick) begin
      half_cnt_r <= '0;
    end else begin
      half_cnt_r <= half_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n || i_disable) begin
      state_r     <= WATCH;
      pulse_cnt_r <= '0;
    end else begin
      unique case (state_r)
        WATCH: begin
          pulse_cnt_r <= '0;
          if (expired) begin
            state_r <= i_sda_in ? FREE : CLR_LO;
          end
        end
        FREE: begin
          if (activity) begin
            state_r <= WATCH;
          end
        end
        CLR_LO: begin
          if (half_tick) begin
            state_r     <= CLR_HI;
            pulse_cnt_r <= pulse_cnt_r + 1'b1;
          end
        end
        CLR_HI: begin
          if (half_tick) begin
            state_r <= (pulse_cnt_r == 4'(CLEAR_PULSES)) ? WATCH : CLR_LO;
          end
        end
        default: state_r <= WATCH;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_scl_out      <= 1'b0;
      o_scl_oe_n     <= 1'b1;
      o_bus_free     <= 1'b0;
      o_bus_clearing <= 1'b0;
    end else begin
      o_scl_out      <= 1'b0;
      o_scl_oe_n     <= !(state_r == CLR_LO);
      o_bus_free     <= state_r == FREE;
      o_bus_clearing <= state_r == CLR_LO || state_r == CLR_HI;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  a_pulse_bound:   assert property (pulse_cnt_r <= 4'(CLEAR_PULSES))
    else $error("More than nine clear pulses");
  a_clear_ends:    assert property (state_r == CLR_HI && half_tick
                                    && pulse_cnt_r == 4'(CLEAR_PULSES) && !i_disable
                                    |=> state_r == WATCH ##1 o_scl_oe_n)
    else $error("Bus clear did not end after nine pulses");
  a_disable_quiet: assert property (i_disable |=> state_r == WATCH ##1 o_scl_oe_n)
    else $error("Disabled watchdog still active");
  a_free_level:    assert property (expired && state_r == WATCH && i_sda_in && !i_disable
                                    |=> ##1 o_bus_free)
    else $error("Idle high bus not reported free");
  c_bus_free:      cover property (o_bus_free);
  c_bus_clear:     cover property (state_r == CLR_HI && pulse_cnt_r == 4'(CLEAR_PULSES));

endmodule

// ---- design/crc_error_counter.sv ----
// Saturating back-channel CRC error counter with a hold-clear input
`timescale 1ns/100ps
module crc_error_counter #(
  parameter int CNT_W = 16
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst_n,
  input  wire logic             i_clear,
  input  wire logic             i_error,
  output logic      [CNT_W-1:0] o_count
);

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_count <= '0;
    end else if (i_clear) begin
      o_count <= '0;
    end else if (i_error && o_count != '1) begin
      o_count <= o_count + 1'b1;
    end
  end

endmodule

// ---- design/serctl_pkg.sv ----
// Constants and carrier types for the serializer control configuration registers
// Notes on behaviour
// - Mode bit 7 picks undriven-input fallback: 0 high, 1 low; resets to 1.
// - Mode bit 5 holds CRC error counters cleared while 1; software clears it.
// - Mode bit 4 set gates RGB data with display enable; clear passes it.
// - Bus control bits 4:3 set clock-to-data delay 240 to 360ns, 40ns steps.
// - Bus control bit 2 set rejects register writes from the far side.
// - That blocking leaves remote access to local-side bus slaves untouched.
// - Bus control bit 1 picks watchdog timeout: 0 about 1s, 1 about 50us.
// - Bus control bit 0 set disables the bus watchdog; 0 enables it.
// - Data line high and idle for the timeout means the bus is free.
// - Data line low and idle until timeout: drive nine clock pulses.
// - Remote receiver bits 7:1 hold its bus address; 0 disables access.
// - After receive lock the address loads from the control channel.
// - Remote receiver bit 0 set freezes the address against auto load.
// - Per-port address and freeze bit use port two copy when selected.
// - CRC error count reads at 0x0A low byte and 0x0B high byte.
package serctl_pkg;

  localparam logic [7:0] MODE_SELECT_OFFSET   = 8'h04;
  localparam logic [7:0] BUS_CONTROL_OFFSET   = 8'h05;
  localparam logic [7:0] REMOTE_RX_OFFSET     = 8'h06;
  localparam logic [7:0] CRC_COUNT_LO_OFFSET  = 8'h0A;
  localparam logic [7:0] CRC_COUNT_HI_OFFSET  = 8'h0B;

  localparam logic [7:0] MODE_SELECT_RESET    = 8'h80;
  localparam logic [7:0] MODE_SELECT_MASK     = 8'hB0;
  localparam logic [7:0] BUS_CONTROL_RESET    = 8'h00;
  localparam logic [7:0] BUS_CONTROL_MASK     = 8'h1F;
  localparam logic [7:0] REMOTE_RX_RESET      = 8'h00;

  localparam int FAILSAFE_LOW_BIT   = 7;
  localparam int CRC_CLEAR_BIT      = 5;
  localparam int RGB_GATE_BIT       = 4;
  localparam int SDA_DELAY_HI_BIT   = 4;
  localparam int SDA_DELAY_LO_BIT   = 3;
  localparam int LOCAL_WR_DIS_BIT   = 2;
  localparam int WDOG_SPEEDUP_BIT   = 1;
  localparam int WDOG_DISABLE_BIT   = 0;

  localparam int CLK_PERIOD_NS      = 100;
  localparam int SDA_DELAY_BASE_NS  = 240;
  localparam int SDA_DELAY_STEP_NS  = 40;
  localparam int WDOG_LONG_NS       = 1000000000;
  localparam int WDOG_SHORT_NS      = 50000;
  localparam int CLEAR_HALF_NS      = 5000;
  localparam int WDOG_LONG_CYCLES   = WDOG_LONG_NS / CLK_PERIOD_NS;
  localparam int WDOG_SHORT_CYCLES  = WDOG_SHORT_NS / CLK_PERIOD_NS;
  localparam int CLEAR_HALF_CYCLES  = (CLEAR_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLEAR_PULSES       = 9;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       remote;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic [6:0] addr;
    logic       lock;
  } remote_id_s;

endpackage

// ---- design/serializer_control_config_regs.sv ----
// Serializer control configuration registers with watchdog and CRC counters
`timescale 1ns/100ps
module serializer_control_config_regs #(
  parameter int unsigned WDOG_LONG_CYCLES  = serctl_pkg::WDOG_LONG_CYCLES,
  parameter int unsigned WDOG_SHORT_CYCLES = serctl_pkg::WDOG_SHORT_CYCLES,
  parameter int unsigned CLEAR_HALF_CYCLES = serctl_pkg::CLEAR_HALF_CYCLES,
  parameter int          WDOG_CNT_W        = 24,
  parameter int          CRC_CNT_W         = 16,
  parameter int          RGB_W             = 24
) (
  input  wire logic                  i_clock,
  input  wire logic                  i_rst_n,
  input  wire serctl_pkg::reg_req_s  i_reg_req,
  output logic      [7:0]            o_reg_rdata,
  output logic                       o_reg_rd_valid,
  output logic                       o_write_rejected,
  input  wire logic                  i_second_port_select,
  input  wire logic [1:0]            i_crc_error,
  input  wire logic [1:0]            i_rx_lock,
  input  wire logic [1:0]            i_remote_addr_load,
  input  wire logic [6:0]            i_remote_addr_value,
  input  wire logic [RGB_W-1:0]      i_rgb_data,
  input  wire logic                  i_display_enable_strobe,
  output logic      [RGB_W-1:0]      o_rgb_data,
  output logic                       o_failsafe_low,
  output logic      [2:0]            o_sda_delay_cycles,
  input  wire logic                  i_scl_in,
  input  wire logic                  i_sda_in,
  output logic                       o_scl_out,
  output logic                       o_scl_oe_n,
  output logic                       o_bus_free,
  output logic                       o_bus_clearing,
  output logic      [6:0]            o_remote_addr_p0,
  output logic      [6:0]            o_remote_addr_p1,
  output logic      [1:0]            o_remote_access_en
);
  import serctl_pkg::*;

  logic [7:0]           mode_r;
  logic [7:0]           ctrl_r;
  remote_id_s           id_r [0:1];
  logic [CRC_CNT_W-1:0] crc_count [0:1];
  logic                 local_addr;
  logic                 blocked;
  logic                 wr_ok;
  logic                 sel;
  remote_id_s           id_sel;
  logic [CRC_CNT_W-1:0] crc_sel;
  logic [7:0]           rdata_nxt;
  logic                 rd_hit;

  assign sel     = i_second_port_select;
  assign id_sel  = sel ? id_r[1] : id_r[0];
  assign crc_sel = sel ? crc_count[1] : crc_count[0];

  assign local_addr = i_reg_req.addr == MODE_SELECT_OFFSET
                   || i_reg_req.addr == BUS_CONTROL_OFFSET
                   || i_reg_req.addr == REMOTE_RX_OFFSET;
  // Only register writes are gated; remote slave traffic never passes here
  assign blocked = i_reg_req.remote && ctrl_r[LOCAL_WR_DIS_BIT];
  assign wr_ok   = i_reg_req.wr && local_addr && !blocked;

  // Mode select register
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      mode_r <= MODE_SELECT_RESET;
    end else if (wr_ok && i_reg_req.addr == MODE_SELECT_OFFSET) begin
      mode_r <= i_reg_req.wdata & MODE_SELECT_MASK;
    end
  end

  // Bus control register
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      ctrl_r <= BUS_CONTROL_RESET;
    end else if (wr_ok && i_reg_req.addr == BUS_CONTROL_OFFSET) begin
      ctrl_r <= i_reg_req.wdata & BUS_CONTROL_MASK;
    end
  end

  // Remote receiver address, one copy per port
  always_ff @(posedge i_clock) begin
    for (int p = 0; p < 2; p++) begin
      if (!i_rst_n) begin
        id_r[p] <= remote_id_s'(REMOTE_RX_RESET);
      end else if (wr_ok && i_reg_req.addr == REMOTE_RX_OFFSET && sel == 1'(p)) begin
        id_r[p] <= remote_id_s'(i_reg_req.wdata);
      end else if (i_remote_addr_load[p] && i_rx_lock[p] && !id_r[p].lock) begin
        id_r[p].addr <= i_remote_addr_value;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_remote_addr_p0   <= '0;
      o_remote_addr_p1   <= '0;
      o_remote_access_en <= '0;
    end else begin
      o_remote_addr_p0   <= id_r[0].addr;
      o_remote_addr_p1   <= id_r[1].addr;
      o_remote_access_en <= {id_r[1].addr != '0, id_r[0].addr != '0};
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_write_rejected <= 1'b0;
    end else begin
      o_write_rejected <= i_reg_req.wr && local_addr && blocked;
    end
  end

  // CRC error counters per port
  for (genvar g = 0; g < 2; g++) begin : g_crc
    crc_error_counter #(
      .CNT_W (CRC_CNT_W)
    ) u_count (
      .i_clock (i_clock),
      .i_rst_n (i_rst_n),
      .i_clear (mode_r[CRC_CLEAR_BIT]),
      .i_error (i_crc_error[g]),
      .o_count (crc_count[g])
    );
  end

  // Read decode
  always_comb begin
    rdata_nxt = 8'h00;
    rd_hit    = 1'b1;
    unique case (i_reg_req.addr)
      MODE_SELECT_OFFSET:  rdata_nxt = mode_r;
      BUS_CONTROL_OFFSET:  rdata_nxt = ctrl_r;
      REMOTE_RX_OFFSET:    rdata_nxt = id_sel;
      CRC_COUNT_LO_OFFSET: rdata_nxt = crc_sel[7:0];
      CRC_COUNT_HI_OFFSET: rdata_nxt = crc_sel[15:8];
      default:             rd_hit    = 1'b0;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_reg_rdata    <= 8'h00;
      o_reg_rd_valid <= 1'b0;
    end else begin
      o_reg_rd_valid <= i_reg_req.rd && rd_hit;
      if (i_reg_req.rd) begin
        o_reg_rdata <= rdata_nxt;
      end
    end
  end

  // Video path and pin-level configuration
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_rgb_data <= '0;
    end else if (mode_r[RGB_GATE_BIT] && !i_display_enable_strobe) begin
      o_rgb_data <= '0;
    end else begin
      o_rgb_data <= i_rgb_data;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_failsafe_low     <= MODE_SELECT_RESET[FAILSAFE_LOW_BIT];
      o_sda_delay_cycles <= 3'((SDA_DELAY_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    end else begin
      o_failsafe_low     <= mode_r[FAILSAFE_LOW_BIT];
      // Least delay rounds up to whole cycles
      o_sda_delay_cycles <= 3'((SDA_DELAY_BASE_NS
                             + int'(ctrl_r[SDA_DELAY_HI_BIT:SDA_DELAY_LO_BIT]) * SDA_DELAY_STEP_NS
                             + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    end
  end

  bus_watchdog #(
    .LONG_CYCLES  (WDOG_LONG_CYCLES),
    .SHORT_CYCLES (WDOG_SHORT_CYCLES),
    .HALF_CYCLES  (CLEAR_HALF_CYCLES),
    .CNT_W        (WDOG_CNT_W)
  ) u_watchdog (
    .i_clock        (i_clock),
    .i_rst_n        (i_rst_n),
    .i_disable      (ctrl_r[WDOG_DISABLE_BIT]),
    .i_speedup      (ctrl_r[WDOG_SPEEDUP_BIT]),
    .i_scl_in       (i_scl_in),
    .i_sda_in       (i_sda_in),
    .o_scl_out      (o_scl_out),
    .o_scl_oe_n     (o_scl_oe_n),
    .o_bus_free     (o_bus_free),
    .o_bus_clearing (o_bus_clearing)
  );

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  a_failsafe_follow: assert property (wr_ok && i_reg_req.addr == MODE_SELECT_OFFSET
                                      |=> ##1 o_failsafe_low
                                              == $past(i_reg_req.wdata[7], 2))
    else $error("Failsafe level does not follow mode write");
  a_crc_held_clear:  assert property (mode_r[CRC_CLEAR_BIT]
                                      |=> crc_count[0] == '0 && crc_count[1] == '0)
    else $error("CRC counters not held cleared");
  a_rgb_gated:       assert property (mode_r[RGB_GATE_BIT] && !i_display_enable_strobe
                                      |=> o_rgb_data == '0)
    else $error("RGB data not gated by display enable");
  a_rgb_pass:        assert property (!mode_r[RGB_GATE_BIT]
                                      |=> o_rgb_data == $past(i_rgb_data))
    else $error("RGB data not passed when gating off");
  a_sda_delay_max:   assert property (ctrl_r[4:3] == 2'b11 |=> o_sda_delay_cycles == 3'd4)
    else $error("Longest data delay count wrong");
  a_remote_blocked:  assert property (i_reg_req.wr && i_reg_req.remote
                                      && ctrl_r[LOCAL_WR_DIS_BIT]
                                      |=> $stable(mode_r) && $stable(ctrl_r)
                                          && o_write_rejected == $past(local_addr))
    else $error("Remote write reached a blocked register");
  a_ctrl_write:      assert property (i_reg_req.wr && !i_reg_req.remote
                                      && i_reg_req.addr == BUS_CONTROL_OFFSET
                                      |=> ctrl_r == ($past(i_reg_req.wdata) & 8'h1F))
    else $error("Bus control write not stored or reserved bits kept");
  a_access_enable:   assert property (##1 o_remote_access_en[0]
                                      == ($past(id_r[0].addr) != 7'h00))
    else $error("Remote access enable does not track address");
  a_auto_load:       assert property (i_remote_addr_load[0] && i_rx_lock[0] && !id_r[0].lock
                                      && !(wr_ok && i_reg_req.addr == REMOTE_RX_OFFSET && !sel)
                                      |=> id_r[0].addr == $past(i_remote_addr_value))
    else $error("Address not loaded after lock");
  a_frozen_keep:     assert property (id_r[1].lock
                                      && !(wr_ok && i_reg_req.addr == REMOTE_RX_OFFSET && sel)
                                      |=> $stable(id_r[1]))
    else $error("Frozen address changed");
  a_port_read:       assert property (i_reg_req.rd && i_reg_req.addr == REMOTE_RX_OFFSET
                                      |=> o_reg_rdata == $past(sel ? id_r[1] : id_r[0]))
    else $error("Per-port read returned wrong copy");
  a_crc_read_hi:     assert property (i_reg_req.rd && i_reg_req.addr == CRC_COUNT_HI_OFFSET
                                      |=> o_reg_rdata == $past(crc_sel[15:8]))
    else $error("CRC high byte read wrong");
  a_reserved_zero:   assert property (i_reg_req.rd && i_reg_req.addr == MODE_SELECT_OFFSET
                                      |=> o_reg_rdata[6] == 1'b0
                                          && o_reg_rdata[3:0] == 4'h0)
    else $error("Reserved mode bits read nonzero");

  c_remote_reject:   cover property (o_write_rejected);
  c_frozen_load:     cover property (id_r[0].lock && i_remote_addr_load[0] && i_rx_lock[0]);
  c_gated_video:     cover property (mode_r[RGB_GATE_BIT] && !i_display_enable_strobe);

endmodule

// ---- tb/bus_line_model.sv ----
// Far-side bus lines: open-drain clock and data wires with pull-ups
`timescale 1ns/100ps
module bus_line_model (
  input  wire logic i_scl_out,
  input  wire logic i_scl_oe_n,
  input  wire logic i_sda_hold_low,
  output logic      o_scl,
  output logic      o_sda
);
  // Released wires float high through the pull-ups
  assign o_scl = i_scl_oe_n ? 1'b1 : i_scl_out;
  assign o_sda = ~i_sda_hold_low;
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the serializer control configuration registers
`timescale 1ns/100ps
module testbench;
  import serctl_pkg::*;
  logic        i_clock, i_rst_n, sel, strobe, sda_low, scl_out, scl_oe_n, scl, sda;
  logic        rd_valid, wr_rej, rej, fs_low, bus_free, clearing;
  logic [1:0]  crc_err, rx_lock, addr_load, acc_en;
  logic [6:0]  addr_val, addr_p0, addr_p1;
  logic [7:0]  rdata;
  logic [2:0]  dly;
  logic [23:0] rgb_in, rgb_out;
  reg_req_s    req;
  int          fails, cmp_count;

  serializer_control_config_regs #(.WDOG_LONG_CYCLES(200), .WDOG_SHORT_CYCLES(20),
    .CLEAR_HALF_CYCLES(3)) serializer_control_config_regs_inst (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_reg_req(req), .o_reg_rdata(rdata),
    .o_reg_rd_valid(rd_valid), .o_write_rejected(wr_rej), .i_second_port_select(sel),
    .i_crc_error(crc_err), .i_rx_lock(rx_lock), .i_remote_addr_load(addr_load),
    .i_remote_addr_value(addr_val), .i_rgb_data(rgb_in), .i_display_enable_strobe(strobe),
    .o_rgb_data(rgb_out), .o_failsafe_low(fs_low), .o_sda_delay_cycles(dly),
    .i_scl_in(scl), .i_sda_in(sda), .o_scl_out(scl_out), .o_scl_oe_n(scl_oe_n),
    .o_bus_free(bus_free), .o_bus_clearing(clearing), .o_remote_addr_p0(addr_p0),
    .o_remote_addr_p1(addr_p1), .o_remote_access_en(acc_en));

  bus_line_model bus_line_model_inst (.i_scl_out(scl_out), .i_scl_oe_n(scl_oe_n),
    .i_sda_hold_low(sda_low), .o_scl(scl), .o_sda(sda));

  task automatic chk(string nm, logic [23:0] exp, logic [23:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tick(int k = 1);
    repeat (k) @(posedge i_clock);
    #1;
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d, logic rm = 1'b0);
    req = '{1'b1, 1'b0, rm, a, d};
    tick();
    req = '0;
    rej = wr_rej;
    tick();
  endtask

  task automatic rdc(string nm, logic [7:0] a, logic [7:0] exp, logic v = 1'b1);
    req = '{1'b0, 1'b1, 1'b0, a, 8'h00};
    tick();
    req = '0;
    chk(nm, exp, rdata);
    chk("read valid", v, rd_valid);
    tick();
  endtask

  task automatic t_fields();
    rdc("mode reset", 8'h04, 8'h80);
    rdc("bus reset", 8'h05, 8'h00);
    rdc("remote reset", 8'h06, 8'h00);
    chk("failsafe", 1, fs_low);
    wr(8'h04, 8'h7F);
    rdc("mode masked", 8'h04, 8'h30);
    chk("failsafe", 0, fs_low);
    for (int n = 0; n < 4; n++) begin
      wr(8'h05, 8'hE0 | 8'(n << 3));
      rdc("bus masked", 8'h05, 8'(n << 3));
      chk("sda delay", (n < 2) ? 3 : 4, dly);
    end
    rdc("unmapped", 8'h09, 8'h00, 1'b0);
    $display("fields done");
  endtask

  task automatic t_reject();
    wr(8'h05, 8'h04);
    wr(8'h04, 8'h80, 1'b1);
    chk("reject", 1, rej);
    rdc("mode kept", 8'h04, 8'h30);
    wr(8'h07, 8'h55, 1'b1);
    chk("remote other", 0, rej);
    wr(8'h04, 8'h90);
    chk("local accepted", 0, rej);
    rdc("mode local", 8'h04, 8'h90);
    wr(8'h05, 8'h00);
    wr(8'h04, 8'h10, 1'b1);
    chk("remote accepted", 0, rej);
    rdc("mode remote", 8'h04, 8'h10);
    $display("reject done");
  endtask

  task automatic t_video();
    rgb_in = 24'hA5_5A3C;
    tick();
    chk("rgb gated", 0, rgb_out);
    strobe = 1;
    tick();
    chk("rgb strobe", 24'hA5_5A3C, rgb_out);
    wr(8'h04, 8'h00);
    strobe = 0;
    tick();
    chk("rgb pass", 24'hA5_5A3C, rgb_out);
    wr(8'h04, 8'h10);
    $display("video done");
  endtask

  task automatic t_crc();
    crc_err = 2'b01;
    tick(2);
    crc_err = 2'b11;
    tick();
    crc_err = 2'b00;
    rdc("crc low", 8'h0A, 8'h03);
    rdc("crc high", 8'h0B, 8'h00);
    sel = 1;
    rdc("crc port1", 8'h0A, 8'h01);
    sel = 0;
    wr(8'h04, 8'h30);
    crc_err = 2'b01;
    tick(2);
    crc_err = 2'b00;
    rdc("crc held", 8'h0A, 8'h00);
    rdc("clear stays", 8'h04, 8'h30);
    wr(8'h04, 8'h10);
    crc_err = 2'b01;
    tick();
    crc_err = 2'b00;
    rdc("crc resumed", 8'h0A, 8'h01);
    $display("crc done");
  endtask

  task automatic t_remote();
    rx_lock = 2'b11;
    addr_val = 7'h2C;
    addr_load = 2'b01;
    tick();
    addr_load = 2'b00;
    tick();
    chk("auto addr", 7'h2C, addr_p0);
    chk("access", 2'b01, acc_en);
    rdc("remote read", 8'h06, 8'h58);
    wr(8'h06, 8'h35);
    addr_val = 7'h11;
    addr_load = 2'b01;
    tick();
    addr_load = 2'b00;
    tick();
    chk("frozen addr", 7'h1A, addr_p0);
    sel = 1;
    wr(8'h06, 8'h47);
    rdc("port1 read", 8'h06, 8'h47);
    sel = 0;
    addr_load = 2'b11;
    tick();
    addr_load = 2'b00;
    tick();
    chk("port1 addr", 7'h23, addr_p1);
    chk("port0 kept", 7'h1A, addr_p0);
    wr(8'h06, 8'h00);
    tick();
    chk("access off", 2'b10, acc_en);
    $display("remote done");
  endtask

  task automatic t_wdog();
    int n, k;
    logic p;
    n = 0;
    k = 0;
    p = 1;
    wr(8'h05, 8'h02);
    sda_low = 1;
    while (clearing !== 1 && k < 60) begin
      tick();
      k++;
    end
    chk("clear start", 1, clearing);
    chk("scl pulled", 0, scl);
    while (clearing === 1 && k < 200) begin
      if (p && !scl_oe_n) n++;
      p = scl_oe_n;
      tick();
      k++;
    end
    chk("clear pulses", 9, n);
    sda_low = 0;
    k = 0;
    while (bus_free !== 1 && k < 30) begin
      tick();
      k++;
    end
    chk("bus free", 1, bus_free);
    wr(8'h05, 8'h00);
    sda_low = 1;
    tick(100);
    chk("long idle", 0, clearing);
    k = 0;
    while (clearing !== 1 && k < 150) begin
      tick();
      k++;
    end
    chk("long expiry", 1, clearing);
    wr(8'h05, 8'h01);
    tick();
    chk("released", 1, scl_oe_n);
    tick(250);
    chk("disabled", 0, clearing);
    sda_low = 0;
    $display("watchdog done");
  endtask

  task automatic t_reset();
    i_rst_n = 0;
    tick(2);
    i_rst_n = 1;
    rdc("mode again", 8'h04, 8'h80);
    rdc("bus again", 8'h05, 8'h00);
    chk("addr again", 0, addr_p1);
    chk("failsafe again", 1, fs_low);
    $display("reset done");
  endtask

  task automatic end_sim();
    $display("Counts: %0d compared, %0d bad", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    i_clock = 0;
    forever #50 i_clock = ~i_clock;
  end

  initial begin
    #500000;
    fails++;
    end_sim();
  end

  initial begin
    {i_rst_n, sel, strobe, sda_low, crc_err, rx_lock, addr_load, addr_val} = '0;
    req = '0;
    rej = 0;
    rgb_in = 24'h0;
    tick(3);
    i_rst_n = 1;
    t_fields();
    t_reject();
    t_video();
    t_crc();
    t_remote();
    t_wdog();
    t_reset();
    end_sim();
  end
endmodule
